// ### include/mtoi_params.svh
// Constants for the motor thermal overload integrator
`ifndef MTOI_PARAMS_SVH
`define MTOI_PARAMS_SVH
`define MTOI_OFS_LEVEL1 8'h00
`define MTOI_OFS_LEVEL2 8'h04
`define MTOI_OFS_LEVEL3 8'h08
`define MTOI_OFS_CURVE1 8'h0c
`define MTOI_OFS_CURVE2 8'h10
`define MTOI_OFS_CURVE3 8'h14
`define MTOI_OFS_FPT1 8'h18
`define MTOI_OFS_FPT2 8'h1c
`define MTOI_OFS_FPT3 8'h20
`define MTOI_OFS_IPT1 8'h24
`define MTOI_OFS_IPT2 8'h28
`define MTOI_OFS_IPT3 8'h2c
`define MTOI_OFS_WARN 8'h30
`define MTOI_OFS_TERM1 8'h34
`define MTOI_OFS_STATUS 8'h4c
`define MTOI_OFS_CLEAR 8'h50
`define MTOI_OFS_ENABLE 8'h54
`define MTOI_OFS_STATE 8'h58
`define MTOI_RATED_CURRENT 16'h1770
`define MTOI_LEVEL_MIN 16'h04b0
`define MTOI_FREQ_MAX 16'h0fa0
`define MTOI_FREQ_MAX_LARGE 16'h04b0
`define MTOI_BASE_FREQ 16'h0258
`define MTOI_WARN_MAX 8'h64
`define MTOI_THM_FUNC 8'h0d
`define MTOI_TRIP_CODE 8'h05
`define MTOI_ACC_FULL 24'h800000
`define MTOI_ACC_DECAY 24'h000010
`define MTOI_FACT_LOW 9'h09a
`define MTOI_FACT_MID 9'h0cd
`define MTOI_FACT_FULL 9'h100
`define MTOI_CTRL_PERIOD_US 1000
`define MTOI_CLK_MHZ 200
`endif

// ### include/mtoi_pkg.sv
// Types for the motor thermal overload integrator
package mtoi_pkg;
    typedef enum logic [1:0]
    {
        MTOI_CURVE_REDUCED = 2'h0,
        MTOI_CURVE_CONSTANT = 2'h1,
        MTOI_CURVE_FREE = 2'h2
    } mtoi_curve_t;
    typedef enum logic [1:0]
    {
        MTOI_ST_IDLE = 2'h0,
        MTOI_ST_RUN = 2'h1,
        MTOI_ST_TRIP = 2'h3
    } mtoi_state_t;
    typedef logic [15:0] mtoi_amps_t;
endpackage

// ### src/mtoi_integrator.sv
// Motor thermal overload integrator with Avalon-MM register slave
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mtoi_params.svh"
// Function
// - Thermal level clamped to 0.2..1.0 rated
// - Three motor setting sets, selected by input
// - Curve code 00 reduced, 01 constant, 02 free
// - Threshold from level and output frequency
// - Reduced torque scales level down slowly
// - Three breakpoint frequencies, 0..400 or 0..120 Hz
// - Breakpoint currents to rated; zero disables protection
// - Trip when integrated value reaches limit
// - Warning threshold 0..100 percent, 0 disables
// - Warning when integral percentage reaches threshold
// - Full scale is trip, reported with overload code
// - Warning to terminals whose function is 13
module mtoi_integrator #(
    parameter int CTRL_PERIOD_CYCLES = `MTOI_CTRL_PERIOD_US * `MTOI_CLK_MHZ,
    parameter bit LARGE_RATING = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire mtoi_pkg::mtoi_amps_t current_in,
    input wire logic [15:0] freq_in,
    input wire logic [1:0] motor_select_in,
    output logic [4:0] terminal_out,
    output logic relay_out,
    output logic thermal_warning_output_out,
    output logic overload_trip_out,
    output logic [7:0] trip_code_out,
    output logic irq_out
);
    import mtoi_pkg::*;

    mtoi_amps_t level [3];
    mtoi_curve_t curve [3];
    logic [15:0] fpt [3];
    mtoi_amps_t ipt [3];
    logic [7:0] term_func [6];
    logic [7:0] thermal_warning_threshold;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [23:0] acc;
    mtoi_state_t state;
    logic ack;
    logic [31:0] period_cnt;

    wire [7:0] byte_addr = {1'b0, avs_address_in, 2'b00};
    wire bus_req = avs_read_in | avs_write_in;
    wire wr_stb = avs_write_in & ack & clk_en_in;
    wire rd_stb = avs_read_in & ~ack & clk_en_in;
    wire [15:0] wdata16 = avs_writedata_in[15:0];
    wire [15:0] freq_max = LARGE_RATING ? `MTOI_FREQ_MAX_LARGE : `MTOI_FREQ_MAX;
    wire [15:0] lvl_clamped = (wdata16 < `MTOI_LEVEL_MIN) ? `MTOI_LEVEL_MIN :
        (wdata16 > `MTOI_RATED_CURRENT) ? `MTOI_RATED_CURRENT : wdata16;
    wire [15:0] fpt_clamped = (wdata16 > freq_max) ? freq_max : wdata16;
    wire [15:0] ipt_clamped = (wdata16 > `MTOI_RATED_CURRENT) ?
        `MTOI_RATED_CURRENT : wdata16;
    wire [7:0] warn_clamped = (avs_writedata_in[7:0] > `MTOI_WARN_MAX) ?
        `MTOI_WARN_MAX : avs_writedata_in[7:0];
    wire curve_ok = (avs_writedata_in[1:0] != 2'h3);

    // Setting set of the selected motor
    wire [1:0] msel = (motor_select_in == 2'h3) ? 2'h0 : motor_select_in;
    wire [15:0] sel_level = level[msel];
    wire mtoi_curve_t sel_curve = curve[msel];

    // Reduced-torque factor in 1/256 steps
    wire [17:0] f_x3 = {2'b00, freq_in} + {1'b0, freq_in, 1'b0};
    wire [8:0] rt_factor = (f_x3 < {2'b00, `MTOI_BASE_FREQ}) ? `MTOI_FACT_LOW :
        (f_x3 < {1'b0, `MTOI_BASE_FREQ, 1'b0}) ? `MTOI_FACT_MID : `MTOI_FACT_FULL;
    wire [24:0] rt_prod = sel_level * rt_factor;
    wire [15:0] rt_thr = rt_prod[23:8];

    // Free curve: current of breakpoint 1 or 2 if the frequency is at or below it, else of breakpoint 3
    wire [15:0] free_thr = (freq_in <= fpt[0]) ? ipt[0] :
        (freq_in <= fpt[1]) ? ipt[1] : ipt[2];
    wire free_off = (ipt[0] == 16'h0000) | (ipt[1] == 16'h0000) |
        (ipt[2] == 16'h0000);
    wire prot_off = (sel_curve == MTOI_CURVE_FREE) & free_off;

    wire [15:0] eff_thr = (sel_curve == MTOI_CURVE_REDUCED) ? rt_thr :
        (sel_curve == MTOI_CURVE_FREE) ? free_thr : sel_level;

    wire tick = (period_cnt == 32'(CTRL_PERIOD_CYCLES - 1)) & clk_en_in;
    wire over = (current_in > eff_thr) & ~prot_off;
    wire [24:0] acc_up = {1'b0, acc} + {9'h000, current_in - eff_thr};
    wire [23:0] acc_up_sat = (acc_up >= {1'b0, `MTOI_ACC_FULL}) ?
        `MTOI_ACC_FULL : acc_up[23:0];
    wire [23:0] acc_dn = (acc > `MTOI_ACC_DECAY) ? acc - `MTOI_ACC_DECAY : 24'h000000;
    wire [23:0] next_acc = over ? acc_up_sat : acc_dn;
    wire trip_now = (acc >= `MTOI_ACC_FULL);
    wire [31:0] acc_pct = acc * 8'h64;
    wire [31:0] warn_lim = thermal_warning_threshold * `MTOI_ACC_FULL;
    wire warn_now = (thermal_warning_threshold != 8'h00) & (acc_pct >= warn_lim);
    wire clr_wr = wr_stb & (byte_addr == `MTOI_OFS_CLEAR);

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            period_cnt <= 32'h00000000;
        else if (clk_en_in)
            period_cnt <= tick ? 32'h00000000 : period_cnt + 32'h00000001;
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            acc <= 24'h000000;
            state <= MTOI_ST_IDLE;
        end
        else if (clk_en_in)
        begin
            case (state)
                MTOI_ST_IDLE:
                begin
                    if (tick)
                        state <= MTOI_ST_RUN;
                end
                MTOI_ST_RUN:
                begin
                    if (trip_now)
                        state <= MTOI_ST_TRIP;
                    else if (tick)
                        acc <= next_acc;
                end
                MTOI_ST_TRIP:
                begin
                    if (clr_wr & avs_writedata_in[0])
                    begin
                        acc <= 24'h000000;
                        state <= MTOI_ST_IDLE;
                    end
                end
                default:
                    state <= MTOI_ST_IDLE;
            endcase
        end
    end

    wire tripped = (state == MTOI_ST_TRIP);
    wire [1:0] events = {warn_now, tripped};

    // Register writes
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_motor
            wire [7:0] a_lvl = `MTOI_OFS_LEVEL1 + 8'(4 * gi);
            wire [7:0] a_crv = `MTOI_OFS_CURVE1 + 8'(4 * gi);
            wire [7:0] a_fpt = `MTOI_OFS_FPT1 + 8'(4 * gi);
            wire [7:0] a_ipt = `MTOI_OFS_IPT1 + 8'(4 * gi);
            always_ff @(posedge clk_sys_in or posedge reset_in)
            begin
                if (reset_in)
                begin
                    level[gi] <= `MTOI_RATED_CURRENT;
                    curve[gi] <= MTOI_CURVE_REDUCED;
                    fpt[gi] <= 16'h0000;
                    ipt[gi] <= `MTOI_RATED_CURRENT;
                end
                else if (wr_stb)
                begin
                    if (byte_addr == a_lvl)
                        level[gi] <= lvl_clamped;
                    if ((byte_addr == a_crv) & curve_ok)
                        curve[gi] <= mtoi_curve_t'(avs_writedata_in[1:0]);
                    if (byte_addr == a_fpt)
                        fpt[gi] <= fpt_clamped;
                    if (byte_addr == a_ipt)
                        ipt[gi] <= ipt_clamped;
                end
            end
        end
        for (gi = 0; gi < 6; gi++)
        begin : g_term
            wire [7:0] a_term = `MTOI_OFS_TERM1 + 8'(4 * gi);
            always_ff @(posedge clk_sys_in or posedge reset_in)
            begin
                if (reset_in)
                    term_func[gi] <= 8'h00;
                else if (wr_stb & (byte_addr == a_term))
                    term_func[gi] <= avs_writedata_in[7:0];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            thermal_warning_threshold <= 8'h00;
            irq_enable <= 2'h0;
            irq_status <= 2'h0;
        end
        else if (clk_en_in)
        begin
            if (wr_stb & (byte_addr == `MTOI_OFS_WARN))
                thermal_warning_threshold <= warn_clamped;
            if (wr_stb & (byte_addr == `MTOI_OFS_ENABLE))
                irq_enable <= avs_writedata_in[1:0];
            irq_status <= (irq_status & ~(clr_wr ? avs_writedata_in[1:0] : 2'h0)) | events;
        end
    end

    // Read mux
    wire [3:0] ridx = 4'(avs_address_in);
    wire [31:0] rd_data =
        (byte_addr <= `MTOI_OFS_LEVEL3) ? {16'h0000, level[ridx[1:0]]} :
        (byte_addr <= `MTOI_OFS_CURVE3) ? {30'h0, curve[2'(ridx - 4'h3)]} :
        (byte_addr <= `MTOI_OFS_FPT3) ? {16'h0000, fpt[2'(ridx - 4'h6)]} :
        (byte_addr <= `MTOI_OFS_IPT3) ? {16'h0000, ipt[2'(ridx - 4'h9)]} :
        (byte_addr == `MTOI_OFS_WARN) ? {24'h000000, thermal_warning_threshold} :
        (byte_addr < `MTOI_OFS_STATUS) ?
            {24'h000000, term_func[3'(avs_address_in - 5'h0d)]} :
        (byte_addr == `MTOI_OFS_STATUS) ? {30'h0, irq_status} :
        (byte_addr == `MTOI_OFS_ENABLE) ? {30'h0, irq_enable} :
        (byte_addr == `MTOI_OFS_STATE) ? {trip_code_out, acc} : 32'h00000000;

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ack <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end
        else if (clk_en_in)
        begin
            ack <= bus_req & ~ack;
            if (rd_stb)
                avs_readdata_out <= rd_data;
        end
    end

    assign avs_waitrequest_out = bus_req & (~ack | ~clk_en_in);

    // Outputs
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            thermal_warning_output_out <= 1'b0;
            overload_trip_out <= 1'b0;
            trip_code_out <= 8'h00;
        end
        else if (clk_en_in)
        begin
            thermal_warning_output_out <= warn_now;
            overload_trip_out <= tripped;
            trip_code_out <= tripped ? `MTOI_TRIP_CODE : 8'h00;
        end
    end

    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_tout
            assign terminal_out[gi] = thermal_warning_output_out &
                (term_func[gi] == `MTOI_THM_FUNC);
        end
    endgenerate
    assign relay_out = thermal_warning_output_out & (term_func[5] == `MTOI_THM_FUNC);
    assign irq_out = |(irq_status & irq_enable);

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    chk_level_range: assert property (level[0] >= `MTOI_LEVEL_MIN &&
        level[0] <= `MTOI_RATED_CURRENT) else $error("level out of range");
    chk_curve_code: assert property (curve[1] != 2'h3)
        else $error("illegal curve code");
    chk_trip_entry: assert property (clk_en_in && state == MTOI_ST_RUN && trip_now
        |=> state == MTOI_ST_TRIP) else $error("trip not taken");
    chk_trip_code: assert property (tripped && clk_en_in
        |=> overload_trip_out && trip_code_out == `MTOI_TRIP_CODE)
        else $error("trip code wrong");
    chk_warn_off: assert property (thermal_warning_threshold == 8'h00 && clk_en_in
        |=> !thermal_warning_output_out) else $error("warning not suppressed");
    chk_warn_full: assert property (clk_en_in && thermal_warning_threshold != 8'h00
        && acc >= `MTOI_ACC_FULL |=> thermal_warning_output_out)
        else $error("warning missing at full");
    chk_term_route: assert property (term_func[0] == `MTOI_THM_FUNC
        |-> terminal_out[0] == thermal_warning_output_out)
        else $error("terminal route wrong");
    chk_trip_hold: assert property (tripped && !clr_wr && clk_en_in |=> tripped)
        else $error("trip released");
    chk_acc_bound: assert property (acc <= `MTOI_ACC_FULL)
        else $error("accumulator overflow");
    chk_free_off: assert property (state == MTOI_ST_RUN && prot_off && tick
        |=> acc <= $past(acc)) else $error("free off still integrates");
endmodule
`default_nettype wire

// ### sim/mtoi_drive_model.sv
// Behavioural model of the drive's current and frequency sensing
`timescale 1ns/1ps
`default_nettype none
module mtoi_drive_model (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire mtoi_pkg::mtoi_amps_t amps_cmd_in,
    input wire logic [15:0] freq_cmd_in,
    input wire logic trip_in,
    output var mtoi_pkg::mtoi_amps_t current_out,
    output logic [15:0] freq_out
);
    import mtoi_pkg::*;
    // A tripped drive shuts its output stage, so the sensed current drops
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            current_out <= 16'h0000;
            freq_out <= 16'h0000;
        end
        else
        begin
            current_out <= trip_in ? 16'h0000 : amps_cmd_in;
            freq_out <= freq_cmd_in;
        end
    end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Testbench for the motor thermal overload integrator
`timescale 1ns/1ps
`default_nettype none
`include "mtoi_params.svh"
module tb_top;
    import mtoi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    mtoi_amps_t amps = 16'h0;
    mtoi_amps_t cur;
    logic [15:0] hz = 16'h0;
    logic [15:0] frq;
    logic [1:0] msel = 2'h0;
    logic [4:0] term;
    logic relay, warn, trip, irq;
    logic [7:0] code;
    logic [31:0] q, q0, ql;
    logic [31:0] rdat_l;
    int fail_count = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    mtoi_integrator #(.CTRL_PERIOD_CYCLES(4), .LARGE_RATING(1'b0)) dut (
        .clk_sys_in(clk), .reset_in(rst), .clk_en_in(clk_en), .avs_address_in(adr),
        .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdat),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .current_in(cur),
        .freq_in(frq), .motor_select_in(msel), .terminal_out(term), .relay_out(relay),
        .thermal_warning_output_out(warn), .overload_trip_out(trip),
        .trip_code_out(code), .irq_out(irq));
    mtoi_drive_model drv (.clk_sys_in(clk), .reset_in(rst), .amps_cmd_in(amps),
        .freq_cmd_in(hz), .trip_in(trip), .current_out(cur), .freq_out(frq));
    mtoi_integrator #(.CTRL_PERIOD_CYCLES(4), .LARGE_RATING(1'b1)) dut_large (
        .clk_sys_in(clk), .reset_in(rst), .clk_en_in(clk_en), .avs_address_in(adr),
        .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdat),
        .avs_readdata_out(rdat_l), .avs_waitrequest_out(), .current_in(cur),
        .freq_in(frq), .motor_select_in(msel), .terminal_out(), .relay_out(),
        .thermal_warning_output_out(), .overload_trip_out(),
        .trip_code_out(), .irq_out());
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // One Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a[6:2];
        wdat <= d;
        wr_s <= w;
        rd_s <= ~w;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 100);
        q = rdat;
        ql = rdat_l;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        chk("waitrequest", 32'h0, {31'h0, wreq});
    endtask
    task automatic do_reset(input int n);
        rst <= 1'b1;
        amps <= 16'h0;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
    endtask
    // Compares the accumulator over ten control periods
    task automatic trend(input string nm, input logic grow);
        repeat (12) @(posedge clk);
        bus(1'b0, `MTOI_OFS_STATE, 32'h0);
        q0 = q;
        repeat (40) @(posedge clk);
        bus(1'b0, `MTOI_OFS_STATE, 32'h0);
        chk(nm, {31'h0, grow}, {31'h0, q[23:0] > q0[23:0]});
    endtask
    task automatic wait_on(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic t_regs();
        bus(1'b0, `MTOI_OFS_LEVEL1, 32'h0);
        chk("level1 reset", `MTOI_RATED_CURRENT, q);
        bus(1'b1, `MTOI_OFS_LEVEL2, 32'h64);
        bus(1'b0, `MTOI_OFS_LEVEL2, 32'h0);
        chk("level low clamp", `MTOI_LEVEL_MIN, q);
        bus(1'b1, `MTOI_OFS_LEVEL3, 32'h1b58);
        bus(1'b0, `MTOI_OFS_LEVEL3, 32'h0);
        chk("level high clamp", `MTOI_RATED_CURRENT, q);
        bus(1'b1, `MTOI_OFS_CURVE2, 32'h2);
        bus(1'b1, `MTOI_OFS_CURVE2, 32'h3);
        bus(1'b0, `MTOI_OFS_CURVE2, 32'h0);
        chk("curve code 3", 32'h2, q);
        bus(1'b1, `MTOI_OFS_FPT1, 32'h1388);
        bus(1'b0, `MTOI_OFS_FPT1, 32'h0);
        chk("freq point clamp", `MTOI_FREQ_MAX, q);
        chk("large freq clamp", `MTOI_FREQ_MAX_LARGE, ql);
        bus(1'b1, `MTOI_OFS_IPT3, 32'h2000);
        bus(1'b0, `MTOI_OFS_IPT3, 32'h0);
        chk("current point clamp", `MTOI_RATED_CURRENT, q);
        bus(1'b1, `MTOI_OFS_WARN, 32'hc8);
        bus(1'b0, `MTOI_OFS_WARN, 32'h0);
        chk("warn clamp", `MTOI_WARN_MAX, q);
        bus(1'b0, 8'h7c, 32'h0);
        chk("unmapped read", 32'h0, q);
        bus(1'b1, `MTOI_OFS_STATUS, 32'h3);
        bus(1'b0, `MTOI_OFS_STATUS, 32'h0);
        chk("status read only", 32'h0, q);
        clk_en <= 1'b0;
        fork
            bus(1'b0, `MTOI_OFS_LEVEL2, 32'h0);
            begin
                repeat (5) @(posedge clk);
                chk("stall waitrequest", 32'h1, {31'h0, wreq});
                clk_en <= 1'b1;
            end
        join
        chk("level after stall", `MTOI_LEVEL_MIN, q);
    endtask
    task automatic t_curves();
        do_reset(3);
        bus(1'b1, `MTOI_OFS_CURVE1, 32'h1);
        bus(1'b1, `MTOI_OFS_CURVE2, 32'h1);
        bus(1'b1, `MTOI_OFS_LEVEL2, `MTOI_LEVEL_MIN);
        hz <= 16'h0258;
        amps <= 16'h0bb8;
        trend("motor1 level", 1'b0);
        msel <= 2'h1;
        trend("motor2 level", 1'b1);
        msel <= 2'h0;
        bus(1'b1, `MTOI_OFS_CURVE1, 32'h0);
        amps <= 16'h0fa0;
        hz <= 16'h0064;
        trend("reduced at 10 Hz", 1'b1);
        hz <= 16'h012c;
        amps <= 16'h1388;
        trend("reduced at 30 Hz", 1'b1);
        hz <= 16'h02bc;
        trend("reduced at 70 Hz", 1'b0);
        bus(1'b1, `MTOI_OFS_CURVE1, 32'h2);
        bus(1'b1, `MTOI_OFS_LEVEL1, `MTOI_RATED_CURRENT);
        bus(1'b1, `MTOI_OFS_FPT1, 32'h64);
        bus(1'b1, `MTOI_OFS_FPT2, 32'h12c);
        bus(1'b1, `MTOI_OFS_FPT3, 32'h258);
        bus(1'b1, `MTOI_OFS_IPT1, 32'h7d0);
        bus(1'b1, `MTOI_OFS_IPT2, 32'hfa0);
        hz <= 16'h00c8;
        amps <= 16'h0bb8;
        trend("free below point", 1'b0);
        amps <= 16'h1388;
        trend("free above point", 1'b1);
        bus(1'b1, `MTOI_OFS_IPT2, 32'h0);
        trend("free point zero", 1'b0);
    endtask
    task automatic t_warn();
        do_reset(3);
        bus(1'b1, `MTOI_OFS_CURVE1, 32'h1);
        bus(1'b1, `MTOI_OFS_LEVEL1, `MTOI_LEVEL_MIN);
        bus(1'b1, `MTOI_OFS_WARN, 32'h32);
        bus(1'b1, `MTOI_OFS_TERM1, `MTOI_THM_FUNC);
        bus(1'b1, `MTOI_OFS_TERM1 + 8'h14, `MTOI_THM_FUNC);
        bus(1'b1, `MTOI_OFS_ENABLE, 32'h2);
        amps <= 16'hffff;
        wait_on(warn);
        amps <= 16'h0;
        chk("no trip at warning", 32'h0, trip);
        chk("terminal route", 32'h1, term);
        chk("relay route", 32'h1, relay);
        chk("warning irq", 32'h1, irq);
        bus(1'b0, `MTOI_OFS_STATE, 32'h0);
        chk("acc at half scale", 32'h1, q[23:22]);
        bus(1'b1, `MTOI_OFS_ENABLE, 32'h0);
        @(posedge clk);
        chk("irq masked", 32'h0, irq);
        bus(1'b1, `MTOI_OFS_ENABLE, 32'h2);
        bus(1'b1, `MTOI_OFS_WARN, `MTOI_WARN_MAX);
        bus(1'b1, `MTOI_OFS_CLEAR, 32'h2);
        repeat (2) @(posedge clk);
        chk("warning below 100", 32'h0, {term, relay, warn, irq});
        bus(1'b0, `MTOI_OFS_STATUS, 32'h0);
        chk("status cleared", 32'h0, q);
        amps <= 16'hffff;
        wait_on(trip);
        chk("warning at full", 32'h1, warn);
    endtask
    task automatic t_trip();
        do_reset(3);
        bus(1'b1, `MTOI_OFS_CURVE1, 32'h1);
        bus(1'b1, `MTOI_OFS_LEVEL1, `MTOI_LEVEL_MIN);
        bus(1'b1, `MTOI_OFS_TERM1, `MTOI_THM_FUNC);
        bus(1'b1, `MTOI_OFS_ENABLE, 32'h1);
        amps <= 16'hffff;
        wait_on(trip);
        chk("trip code", `MTOI_TRIP_CODE, code);
        chk("trip irq", 32'h1, irq);
        chk("warning off at 0", 32'h0, {term, warn});
        bus(1'b0, `MTOI_OFS_STATE, 32'h0);
        chk("state code", `MTOI_TRIP_CODE, q[31:24]);
        chk("acc full", 32'h1, {31'h0, q[23:0] > 24'h7fff00});
        repeat (40) @(posedge clk);
        chk("trip held", 32'h1, trip);
        bus(1'b1, `MTOI_OFS_CLEAR, 32'h1);
        repeat (2) @(posedge clk);
        chk("trip cleared", 32'h0, {trip, code});
        do_reset(3);
        @(posedge clk);
        chk("trip after reset", 32'h0, {trip, code});
    endtask
    initial
    begin
        do_reset(20);
        t_regs();
        t_curves();
        t_warn();
        t_trip();
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("MISMATCH watchdog expected done seen timeout");
        test_done();
    end
endmodule
`default_nettype wire
